// >>> lcd_host_regs.sv
// Host register file of a bit-map LCD driver, with its constants package.
// Assumes every host pin is already synchronous to core_clk and that the
// oscillator input is a slow level sampled at core_clk.
//
// Function
// - Oscillator clock echoed on clock output except in standby
// - Select low hits pointer, high hits selected
// - Access only with chip select; else float
// - Register number picks pixel/column/row/setup
// - Reset returns register number to pixel
// - Memory access sets busy, eight oscillator clocks
// - Busy blocks all but pointer register
// - Busy set during reset, bus reads zero; clears after
// - Serial output floats while reset low
// - Standby bit; reset returns to normal
// - Screen bit; reset turns display off
// - Serial lock blocks non-pointer writes
// - Lock clears on reset and select fall
// - Serial float bit, reset one, parallel zero
// - Pixel port accesses RAM at pointers
// - Setup bit six picks word length
// - Six-bit mode masks pixel bits 7:6
// - Reset leaves pixel data untouched
// - Pixel access advances address counter
// - Column pointer holds horizontal address
`timescale 1ns/1ps
`default_nettype none

package lcd_host_pkg;
    // Pointer register fields
    localparam int BUSY_BIT = 7;
    localparam int STANDBY_BIT = 6;
    localparam int SCREEN_BIT = 5;
    localparam int LOCK_BIT = 4;
    localparam int FLOAT_BIT = 3;
    localparam logic [7:0] PTR_RESET = 8'h08;
    // Register numbers
    localparam logic [1:0] SEL_PIXEL = 2'h0;
    localparam logic [1:0] SEL_COLUMN = 2'h1;
    localparam logic [1:0] SEL_ROW = 2'h2;
    localparam logic [1:0] SEL_SETUP = 2'h3;
    // Setup register fields
    localparam int INC_BIT = 7;
    localparam int WORD_LEN_BIT = 6;
    localparam logic [7:0] SETUP_WMASK = 8'hdf;
    // Address geometry
    localparam logic [4:0] COL_MAX_8 = 5'h0f;
    localparam logic [4:0] COL_MAX_6 = 5'h15;
    localparam logic [5:0] ROW_MAX_48 = 6'h2f;
    localparam logic [5:0] ROW_MAX_44 = 6'h2b;
    localparam logic [5:0] ROW_MAX_41 = 6'h28;
    localparam logic [5:0] ROW_MAX_33 = 6'h20;
    localparam int RAM_COLS = 22;
    localparam int RAM_ROWS = 48;
    localparam int RAM_DEPTH = RAM_COLS * RAM_ROWS;
    localparam logic [7:0] COL_WMASK = 8'h1f;
    localparam logic [7:0] ROW_WMASK = 8'h3f;
    localparam logic [7:0] PIX6_MASK = 8'h3f;
    // Busy length in oscillator clocks
    localparam logic [3:0] BUSY_OSC_CLOCKS = 4'h8;

    // Host pins, all sampled at core_clk
    typedef struct packed {
        logic csN;
        logic rdN;
        logic wrN;
        logic registerSelectPin;
        logic serialMode;
        logic shiftClock;
        logic si;
        logic [7:0] dbIn;
    } host_pins_s;

    // Pin drivers; enables are low while driving
    typedef struct packed {
        logic [7:0] dbOut;
        logic dbOeN;
        logic so;
        logic soOeN;
    } host_drive_s;
endpackage : lcd_host_pkg

module lcd_host_regs #(
    parameter int COL_W = 5,
    parameter int ROW_W = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Host pins
    input wire lcd_host_pkg::host_pins_s hostIn,
    output lcd_host_pkg::host_drive_s hostOut,
    // Oscillator
    input wire logic oscInput,
    output logic oscClockOut,
    // Panel control
    output logic screenOn,
    output logic standbyMode
);
    localparam int AW = $clog2(lcd_host_pkg::RAM_DEPTH);

    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] setup;
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
        logic [3:0] busyCnt;
        logic busy;
        logic prevWrN;
        logic prevRdN;
        logic prevSelectPin;
        logic prevShiftClock;
        logic oscQ;
        logic [7:0] shIn;
        logic [7:0] shOut;
        logic [7:0] dbOut;
        logic [lcd_host_pkg::RAM_DEPTH-1:0][7:0] ram;
    } state_s;

    state_s s_q;
    state_s s_d;

    // Largest row address for the duty code
    function automatic logic [ROW_W-1:0] rowMax(input logic [1:0] duty);
        case (duty)
            2'h0: rowMax = ROW_W'(lcd_host_pkg::ROW_MAX_48);
            2'h1: rowMax = ROW_W'(lcd_host_pkg::ROW_MAX_44);
            2'h2: rowMax = ROW_W'(lcd_host_pkg::ROW_MAX_41);
            default: rowMax = ROW_W'(lcd_host_pkg::ROW_MAX_33);
        endcase
    endfunction : rowMax

    // RAM word index from pointers
    function automatic logic [AW-1:0] ramIndex(input logic [COL_W-1:0] c,
                                              input logic [ROW_W-1:0] r);
        ramIndex = AW'(r * lcd_host_pkg::RAM_COLS + c);
    endfunction : ramIndex

    // Read view of one register; busy sits in the pointer register
    function automatic logic [7:0] readReg(input state_s st, input logic selHigh,
                                           input logic serial);
        logic [7:0] v;
        logic [7:0] px;
        v = 8'h00;
        px = st.ram[ramIndex(st.col, st.row)];
        if (!selHigh)
        begin
            v = st.ptr;
            v[lcd_host_pkg::BUSY_BIT] = st.busy;
            if (!serial)
            begin
                v[lcd_host_pkg::LOCK_BIT] = 1'b0;
                v[lcd_host_pkg::FLOAT_BIT] = 1'b0;
            end
        end
        else if (!st.busy)
        begin
            case (st.ptr[1:0])
                lcd_host_pkg::SEL_PIXEL: v = st.setup[lcd_host_pkg::WORD_LEN_BIT] ?
                    (px & lcd_host_pkg::PIX6_MASK) : px;
                lcd_host_pkg::SEL_COLUMN: v = 8'(st.col);
                lcd_host_pkg::SEL_ROW: v = 8'(st.row);
                default: v = st.setup & lcd_host_pkg::SETUP_WMASK;
            endcase
        end
        readReg = v;
    endfunction : readReg

    logic serial;
    logic wrFall;
    logic wrRise;
    logic rdRise;
    logic doWrite;
    logic doRead;
    logic [7:0] wrData;
    logic colWrap;
    logic rowWrap;
    logic [4:0] colMax;
    logic [ROW_W-1:0] rowLim;

    assign serial = hostIn.serialMode;
    assign wrFall = s_q.prevWrN && !hostIn.wrN;
    assign wrRise = !s_q.prevWrN && hostIn.wrN;
    assign rdRise = !s_q.prevRdN && hostIn.rdN;
    // Serial latches on the write strobe fall, parallel writes on its rise
    assign doWrite = !hostIn.csN && (serial ? wrFall : wrRise);
    assign doRead = !hostIn.csN && !serial && rdRise;
    assign wrData = serial ? s_q.shIn : hostIn.dbIn;
    assign colMax = s_q.setup[lcd_host_pkg::WORD_LEN_BIT] ? lcd_host_pkg::COL_MAX_6 :
        lcd_host_pkg::COL_MAX_8;
    assign rowLim = rowMax(s_q.setup[1:0]);
    assign colWrap = s_q.col == COL_W'(colMax);
    assign rowWrap = s_q.row == rowLim;

    // Next state of the whole register file
    always_comb
    begin
        logic pixelHit;
        logic locked;
        logic oscRise;
        logic [7:0] px;
        s_d = s_q;
        pixelHit = 1'b0;
        locked = serial && s_q.ptr[lcd_host_pkg::LOCK_BIT];
        oscRise = oscInput && !s_q.oscQ;
        px = wrData;
        s_d.prevWrN = hostIn.wrN;
        s_d.prevRdN = hostIn.rdN;
        s_d.prevSelectPin = hostIn.registerSelectPin;
        s_d.prevShiftClock = hostIn.shiftClock;
        s_d.oscQ = oscInput;
        s_d.dbOut = readReg(s_q, hostIn.registerSelectPin, serial);

        // Reset leaves busy up with an empty count, so release clears it at once
        if (s_q.busy && s_q.busyCnt == 4'h0)
        begin
            s_d.busy = 1'b0;
        end
        // Busy counts oscillator clocks; the counter freezes in standby
        else if (s_q.busy && oscRise && !s_q.ptr[lcd_host_pkg::STANDBY_BIT])
        begin
            if (s_q.busyCnt <= 4'h1)
            begin
                s_d.busy = 1'b0;
                s_d.busyCnt = 4'h0;
            end
            else
            begin
                s_d.busyCnt = s_q.busyCnt - 4'h1;
            end
        end

        // Serial shifting: in on rise, out on fall of the shift clock
        if (serial && !hostIn.csN && hostIn.shiftClock && !s_q.prevShiftClock)
        begin
            s_d.shIn = {s_q.shIn[6:0], hostIn.si};
        end
        if (serial && !hostIn.shiftClock && s_q.prevShiftClock)
        begin
            s_d.shOut = {s_q.shOut[6:0], 1'b0};
        end

        // Lock drops on every fall of register select
        if (serial && s_q.prevSelectPin && !hostIn.registerSelectPin)
        begin
            s_d.ptr[lcd_host_pkg::LOCK_BIT] = 1'b0;
        end

        if (doWrite && !hostIn.registerSelectPin)
        begin
            // Busy is read only; lock and float exist only in serial mode
            s_d.ptr[lcd_host_pkg::STANDBY_BIT] = wrData[lcd_host_pkg::STANDBY_BIT];
            s_d.ptr[lcd_host_pkg::SCREEN_BIT] = wrData[lcd_host_pkg::SCREEN_BIT];
            s_d.ptr[1:0] = wrData[1:0];
            if (serial)
            begin
                s_d.ptr[lcd_host_pkg::LOCK_BIT] = wrData[lcd_host_pkg::LOCK_BIT];
                s_d.ptr[lcd_host_pkg::FLOAT_BIT] = wrData[lcd_host_pkg::FLOAT_BIT];
            end
            // Leaving standby restarts both pointers at the origin
            if (s_q.ptr[lcd_host_pkg::STANDBY_BIT] && !wrData[lcd_host_pkg::STANDBY_BIT])
            begin
                s_d.col = '0;
                s_d.row = '0;
            end
        end
        else if (doWrite && hostIn.registerSelectPin && !s_q.busy && !locked)
        begin
            case (s_q.ptr[1:0])
                lcd_host_pkg::SEL_PIXEL:
                begin
                    if (s_q.setup[lcd_host_pkg::WORD_LEN_BIT])
                    begin
                        px = wrData & lcd_host_pkg::PIX6_MASK;
                    end
                    s_d.ram[ramIndex(s_q.col, s_q.row)] = px;
                    pixelHit = 1'b1;
                end
                lcd_host_pkg::SEL_COLUMN: s_d.col = COL_W'(wrData & lcd_host_pkg::COL_WMASK);
                lcd_host_pkg::SEL_ROW: s_d.row = ROW_W'(wrData & lcd_host_pkg::ROW_WMASK);
                default: s_d.setup = wrData & lcd_host_pkg::SETUP_WMASK;
            endcase
        end
        else if (hostIn.registerSelectPin && !s_q.busy &&
                 s_q.ptr[1:0] == lcd_host_pkg::SEL_PIXEL &&
                 (doRead || (doWrite && locked)))
        begin
            // A locked serial latch is a pixel read
            pixelHit = 1'b1;
        end

        // Pixel access: start busy and step the address counter
        if (pixelHit)
        begin
            s_d.busy = 1'b1;
            s_d.busyCnt = lcd_host_pkg::BUSY_OSC_CLOCKS;
            if (s_q.setup[lcd_host_pkg::INC_BIT])
            begin
                s_d.col = colWrap ? '0 : s_q.col + COL_W'(1);
                if (colWrap)
                begin
                    s_d.row = rowWrap ? '0 : s_q.row + ROW_W'(1);
                end
            end
            else
            begin
                s_d.row = rowWrap ? '0 : s_q.row + ROW_W'(1);
                if (rowWrap)
                begin
                    s_d.col = colWrap ? '0 : s_q.col + COL_W'(1);
                end
            end
        end

        // Serial answer loaded after each latch, busy included
        if (serial && doWrite)
        begin
            s_d.shOut = readReg(s_d, hostIn.registerSelectPin, serial);
        end
    end

    // Registers; setup and pixel storage stay out of the reset branch, so they hold
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.ptr <= lcd_host_pkg::PTR_RESET;
            s_q.col <= '0;
            s_q.row <= '0;
            s_q.busyCnt <= 4'h0;
            s_q.busy <= 1'b1;
            s_q.prevWrN <= 1'b1;
            s_q.prevRdN <= 1'b1;
            s_q.prevSelectPin <= 1'b0;
            s_q.prevShiftClock <= 1'b1;
            s_q.oscQ <= 1'b0;
            s_q.shIn <= 8'h00;
            s_q.shOut <= 8'h00;
            s_q.dbOut <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Pin drivers; serial float bit resets to one, so the pin floats in reset
    always_comb
    begin
        hostOut.dbOut = s_q.dbOut;
        hostOut.dbOeN = hostIn.csN || hostIn.rdN || serial;
        hostOut.so = s_q.shOut[7];
        hostOut.soOeN = hostIn.csN || !serial || s_q.ptr[lcd_host_pkg::FLOAT_BIT] ||
            !rst_n;
    end

    // Oscillator echo, held low in standby
    assign oscClockOut = s_q.oscQ && !s_q.ptr[lcd_host_pkg::STANDBY_BIT];
    assign screenOn = s_q.ptr[lcd_host_pkg::SCREEN_BIT];
    assign standbyMode = s_q.ptr[lcd_host_pkg::STANDBY_BIT];
endmodule : lcd_host_regs

`default_nettype wire

// >>> lcd_host_checker.sv
// Port checker for the LCD host register file.
// Assumes it is bound onto lcd_host_regs; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Host pins and drivers
    input wire lcd_host_pkg::host_pins_s hostIn,
    input wire lcd_host_pkg::host_drive_s hostOut,
    // Oscillator and panel
    input wire logic oscInput,
    input wire logic oscClockOut,
    input wire logic screenOn,
    input wire logic standbyMode
);
    default clocking cb @(posedge core_clk); endclocking
    // Parallel pointer write: strobe low, then taken on its release
    sequence strobeLow;
        !hostIn.wrN;
    endsequence
    sequence ptrTaken;
        hostIn.wrN && !hostIn.csN && !hostIn.registerSelectPin && !hostIn.serialMode;
    endsequence
    osc_echo_a: assert property (disable iff (!rst_n)
        (!standbyMode && !$past(standbyMode) && $past(rst_n)) |-> oscClockOut == $past(oscInput))
        else $error("clock output not in step with oscillator");
    osc_standby_a: assert property (disable iff (!rst_n)
        (standbyMode && $past(standbyMode)) |-> !oscClockOut)
        else $error("clock output runs in standby");
    db_enable_a: assert property (disable iff (!rst_n)
        hostOut.dbOeN == (hostIn.csN | hostIn.rdN | hostIn.serialMode))
        else $error("data bus enable wrong");
    so_unselected_a: assert property (disable iff (!rst_n)
        hostIn.csN |-> hostOut.soOeN)
        else $error("serial out driven while unselected");
    so_reset_a: assert property (!rst_n |-> hostOut.soOeN)
        else $error("serial out driven in reset");
    so_parallel_a: assert property (disable iff (!rst_n)
        !hostIn.serialMode |-> hostOut.soOeN)
        else $error("serial out driven in parallel mode");
    ptr_zero_bits_a: assert property (disable iff (!rst_n)
        (!hostIn.registerSelectPin && !hostIn.serialMode) [*3] |->
        hostOut.dbOut[4:2] == 3'h0)
        else $error("pointer reserved bits not zero");
    screen_on_a: assert property (disable iff (!rst_n)
        (strobeLow ##1 ptrTaken ##0 hostIn.dbIn[5]) |-> ##[1:3] screenOn)
        else $error("screen bit not applied");
    standby_on_a: assert property (disable iff (!rst_n)
        (strobeLow ##1 ptrTaken ##0 hostIn.dbIn[6]) |-> ##[1:3] standbyMode)
        else $error("standby bit not applied");
endmodule : lcd_host_checker
bind lcd_host_regs lcd_host_checker i_chk (.core_clk(core_clk), .rst_n(rst_n),
    .hostIn(hostIn), .hostOut(hostOut), .oscInput(oscInput), .oscClockOut(oscClockOut),
    .screenOn(screenOn), .standbyMode(standbyMode));
`default_nettype wire

// >>> lcd_host_model.sv
// Microcomputer host driving the register file pins, parallel or serial.
// Assumes core_clk timing; all moves 2 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model #(
    parameter bit SERIAL = 1'b0
) (
    // Clock
    input wire logic core_clk,
    // Host pins
    output lcd_host_pkg::host_pins_s hostIn,
    input wire lcd_host_pkg::host_drive_s hostOut,
    // Last read result
    output logic [7:0] rdData
);
    event rdDone;
    // Interface strap fixed from time zero; unused pins parked
    initial hostIn = '{1'b1, 1'b1, 1'b1, 1'b0, SERIAL, 1'b1, 1'b0, 8'h00};
    // Write: strobe low one cycle, held until its release is sampled
    task automatic write(input logic sel, input logic [7:0] data);
        @(posedge core_clk);
        #2;
        hostIn.csN = 1'b0;
        hostIn.registerSelectPin = sel;
        hostIn.dbIn = data;
        hostIn.wrN = 1'b0;
        @(posedge core_clk);
        #2;
        hostIn.wrN = 1'b1;
        @(posedge core_clk);
        #2;
        hostIn.csN = 1'b1;
        hostIn.dbIn = ~data; // Released bus must not echo stale data
    endtask : write
    // Read: strobe low two cycles so the lagged data has settled
    task automatic read(input logic sel, input logic note, output logic [7:0] q);
        @(posedge core_clk);
        #2;
        hostIn.csN = 1'b0;
        hostIn.registerSelectPin = sel;
        hostIn.rdN = 1'b0;
        repeat (2) @(posedge core_clk);
        #2;
        q = hostOut.dbOut;
        rdData = q;
        hostIn.rdN = 1'b1;
        @(posedge core_clk);
        #2;
        hostIn.csN = 1'b1;
        if (note)
            ->rdDone;
    endtask : read
    // Serial transfer: eight shift pulses MSB first, then a latch on the strobe fall;
    // q collects the answer loaded by the previous latch
    task automatic xfer(input logic sel, input logic [7:0] data, input logic note,
                        output logic [7:0] q);
        @(posedge core_clk);
        #2;
        hostIn.csN = 1'b0;
        hostIn.registerSelectPin = sel;
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge core_clk);
            #2;
            q[i] = hostOut.soOeN ? !hostOut.so : hostOut.so; // No pull-up: floating reads inverted
            hostIn.shiftClock = 1'b0;
            hostIn.si = data[i];
            @(posedge core_clk);
            #2;
            hostIn.shiftClock = 1'b1;
        end
        @(posedge core_clk);
        #2;
        hostIn.wrN = 1'b0;
        @(posedge core_clk);
        #2;
        hostIn.wrN = 1'b1;
        @(posedge core_clk);
        #2;
        hostIn.csN = 1'b1;
        rdData = q;
        if (note)
            ->rdDone;
    endtask : xfer
    // Register select alone, chip left unselected
    task automatic select(input logic sel);
        @(posedge core_clk);
        #2;
        hostIn.registerSelectPin = sel;
    endtask : select
endmodule : lcd_host_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the LCD host register file.
// Assumes the host model and bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk, rst_n, oscInput, oscClockOut, screenOn, standbyMode;
    lcd_host_pkg::host_pins_s hostIn;
    lcd_host_pkg::host_drive_s hostOut;
    lcd_host_pkg::host_pins_s serIn;
    lcd_host_pkg::host_drive_s serOut;
    logic serScreenOn;
    logic [7:0] expQ[$];
    logic [7:0] q, d;
    int nMismatch, testsRun, seed;
    lcd_host_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .hostIn(hostIn),
        .hostOut(hostOut), .oscInput(oscInput), .oscClockOut(oscClockOut),
        .screenOn(screenOn), .standbyMode(standbyMode));
    lcd_host_model i_host (.core_clk(core_clk), .hostIn(hostIn), .hostOut(hostOut),
        .rdData());
    // Second copy strapped serial, since the strap may not move after power-up
    lcd_host_regs i_dut_ser (.core_clk(core_clk), .rst_n(rst_n), .hostIn(serIn),
        .hostOut(serOut), .oscInput(oscInput), .oscClockOut(), .screenOn(serScreenOn),
        .standbyMode());
    lcd_host_model #(.SERIAL(1'b1)) i_ser (.core_clk(core_clk), .hostIn(serIn),
        .hostOut(serOut), .rdData());
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic expect_rd(input logic sel, input logic [7:0] exp);
        expQ.push_back(exp);
        i_host.read(sel, 1'b1, q);
    endtask : expect_rd
    task automatic expect_ser(input logic sel, input logic [7:0] data,
                              input logic [7:0] exp);
        expQ.push_back(exp);
        i_ser.xfer(sel, data, 1'b1, q);
    endtask : expect_ser
    // Bounded busy poll; a read takes four cycles
    task automatic wait_ready;
        int n;
        n = 0;
        q = 8'h80;
        while (q[7] && n < 20)
        begin
            i_host.read(1'b0, 1'b0, q);
            n++;
        end
        check({7'h0, q[7]}, 8'h00);
    endtask : wait_ready
    task automatic end_of_test;
        $display("Mismatches %0d, comparisons %0d", nMismatch, testsRun);
        if (nMismatch == 0 && testsRun > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // Each read result against the oldest note
    always @(i_host.rdDone)
        check(i_host.rdData, expQ.pop_front());
    always @(i_ser.rdDone)
        check(i_ser.rdData, expQ.pop_front());
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Slow oscillator, eight core cycles a period
    initial
    begin
        oscInput = 1'b0;
        forever
        begin
            repeat (4) @(posedge core_clk);
            #2;
            oscInput = ~oscInput;
        end
    end
    initial
    begin
        repeat (10000) @(posedge core_clk);
        nMismatch++;
        end_of_test();
    end
    initial
    begin
        seed = 19933;
        rst_n = 1'b0;
        repeat (12) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        @(posedge core_clk);
        expect_rd(1'b0, 8'h00);
        check({6'h0, standbyMode, screenOn}, 8'h00);
        i_host.write(1'b0, 8'hff);
        expect_rd(1'b0, 8'h63);
        check({6'h0, standbyMode, screenOn}, 8'h03);
        i_host.write(1'b0, 8'h23);
        expect_rd(1'b0, 8'h23);
        d = 8'($random(seed));
        i_host.write(1'b1, d);
        expect_rd(1'b1, d & lcd_host_pkg::SETUP_WMASK);
        i_host.write(1'b0, 8'h21);
        i_host.write(1'b1, 8'hff);
        expect_rd(1'b1, 8'h1f);
        i_host.write(1'b0, 8'h22);
        i_host.write(1'b1, 8'hff);
        expect_rd(1'b1, 8'h3f);
        // Both word lengths, column stepping, pixel data at row 0
        for (int w = 0; w < 2; w++)
        begin
            i_host.write(1'b0, 8'h23);
            i_host.write(1'b1, {1'b1, w[0], 6'h00});
            i_host.write(1'b0, 8'h21);
            i_host.write(1'b1, 8'h00);
            i_host.write(1'b0, 8'h22);
            i_host.write(1'b1, 8'h00);
            i_host.write(1'b0, 8'h20);
            d = 8'($random(seed));
            i_host.write(1'b1, d);
            expect_rd(1'b0, 8'ha0);
            expect_rd(1'b1, 8'h00);
            i_host.write(1'b0, 8'h21);
            i_host.write(1'b1, 8'h05);
            wait_ready();
            expect_rd(1'b1, 8'h01);
            i_host.write(1'b1, 8'h00);
            i_host.write(1'b0, 8'h20);
            expect_rd(1'b1, (w != 0) ? (d & 8'h3f) : d);
            wait_ready();
        end
        // Serial copy: each transfer returns the answer latched by the one before
        i_ser.xfer(1'b0, 8'h23, 1'b0, q);
        expect_ser(1'b1, 8'ha1, 8'h23);
        expect_ser(1'b0, 8'h33, 8'h81);
        expect_ser(1'b1, 8'h42, 8'h33);
        i_ser.select(1'b0);
        expect_ser(1'b1, 8'h44, 8'h81);
        expect_ser(1'b0, 8'h08, 8'h44);
        check({7'h0, serScreenOn}, 8'h00);
        // Mid-run reset keeps pixel data; pointers return to pixel at the origin
        @(posedge core_clk);
        #2;
        rst_n = 1'b0;
        repeat (3) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        @(posedge core_clk);
        expect_rd(1'b1, d & 8'h3f);
        repeat (2) @(posedge core_clk);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
